// >>> dv/l2p_core_model.sv
// Processor core model issuing addresses and register cycles
`default_nettype none
module l2p_core_model (
  // Clock
  input wire logic            sys_clk,
  // Core outputs
  output l2p_pkg::l2p_cycle_t cycleType,
  output logic [15:0]         logicalAddr,
  output logic [19:0]         dmaAddr,
  output l2p_pkg::l2p_ioreq_t ioReq
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cycleType = l2p_pkg::CYC_IDLE;
    logicalAddr = 16'h0000;
    dmaAddr = 20'h00000;
    ioReq = '0;
  end
  // Register access in an I/O cycle, held over one edge
  task automatic io(input logic w, input logic [7:0] a, d);
    @(negedge sys_clk);
    ioReq <= '{w, !w, a, d};
    cycleType <= l2p_pkg::CYC_IO;
    @(negedge sys_clk);
    ioReq <= '0;
  endtask : io
  // One bus cycle of a given kind
  task automatic bus(input l2p_pkg::l2p_cycle_t c, input logic [15:0] a,
                     input logic [19:0] d);
    @(negedge sys_clk);
    cycleType <= c;
    logicalAddr <= a;
    dmaAddr <= d;
  endtask : bus
endmodule : l2p_core_model
`default_nettype wire

// >>> dv/l2p_mmu_bench.sv
// Self-checking bench of the translation unit
`default_nettype none
module l2p_mmu_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  l2p_pkg::l2p_cycle_t cycleType;
  l2p_pkg::l2p_ioreq_t ioReq;
  l2p_pkg::l2p_regs_t  regsOut;
  logic [19:0] dmaAddr, physAddr;
  logic [15:0] logicalAddr, la;
  logic [7:0]  ioRdData, ub, sb, ab;
  logic        ioRdHit;
  int err_total = 0, n_compared = 0, seed = 14132;
  always #2.5 sys_clk = ~sys_clk;
  l2p_core_model l2p_core_model_inst (.sys_clk, .cycleType, .logicalAddr,
    .dmaAddr, .ioReq);
  l2p_mmu l2p_mmu_inst (.sys_clk, .rst_n, .logicalAddr, .cycleType,
    .dmaAddr, .ioReq, .ioRdData, .ioRdHit, .physAddr, .regsOut);
  function automatic logic [19:0] want(input l2p_pkg::l2p_cycle_t c,
                                        input logic [15:0] a);
    logic [7:0] b;
    if (c == l2p_pkg::CYC_DMA) return dmaAddr;
    if (c != l2p_pkg::CYC_MEM) return {4'h0, a};
    b = a[15:12] >= ab[7:4] ? ub : a[15:12] >= ab[3:0] ? sb : 8'h00;
    return {b + a[15:12], a[11:0]};
  endfunction : want
  task automatic check(input logic [19:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  initial begin
    #20000;
    err_total++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(negedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      l2p_core_model_inst.io(1'b0, 8'h38 + 8'(i), 8'h00);
      check({ioRdHit, ioRdData}, {i < 3, i == 2 ? 8'hF0 : 8'h00});
    end
    $display("reset test done");
    for (int i = 0; i < 50; i++) begin
      ab = 8'($random(seed));
      if (ab[7:4] < ab[3:0]) ab = {ab[3:0], ab[7:4]};
      ub = i == 0 ? 8'hFF : 8'($random(seed));
      sb = 8'($random(seed));
      l2p_core_model_inst.io(1'b1, 8'h38, ub);
      l2p_core_model_inst.io(1'b1, 8'h39, sb);
      l2p_core_model_inst.io(1'b1, 8'h3A, ab);
      for (int j = 0; j < 4; j++) begin
        la = i == 0 ? 16'hFFFF : 16'($random(seed));
        l2p_core_model_inst.bus(l2p_pkg::l2p_cycle_t'(j), la,
          20'($random(seed)));
        #1 check(physAddr, want(cycleType, la));
      end
    end
    $display("mapping test done");
    report_and_stop();
  end
endmodule : l2p_mmu_bench
bind l2p_mmu l2p_mmu_properties #(.PHYS_WIDTH(PHYS_WIDTH)) props_inst (
  .sys_clk, .rst_n, .logicalAddr, .cycleType, .dmaAddr, .ioReq,
  .ioRdData, .ioRdHit, .physAddr, .regsOut);
`default_nettype wire

// >>> dv/l2p_mmu_properties.sv
// Assertions on the translation unit ports
`default_nettype none
module l2p_mmu_properties #(
  parameter int PHYS_WIDTH = 20
) (
  // Clock and reset
  input wire logic                  sys_clk,
  input wire logic                  rst_n,
  // Inputs
  input wire logic [15:0]           logicalAddr,
  input wire l2p_pkg::l2p_cycle_t   cycleType,
  input wire logic [PHYS_WIDTH-1:0] dmaAddr,
  input wire l2p_pkg::l2p_ioreq_t   ioReq,
  // Outputs
  input wire logic [7:0]            ioRdData,
  input wire logic                  ioRdHit,
  input wire logic [PHYS_WIDTH-1:0] physAddr,
  input wire l2p_pkg::l2p_regs_t    regsOut
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int H = PHYS_WIDTH - 12;
  wire logic       m = cycleType == l2p_pkg::CYC_MEM;
  wire logic [3:0] p = logicalAddr[15:12];
  wire logic [7:0] b = regsOut.areaBoundary;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_IO: assert property (cycleType == l2p_pkg::CYC_IO |->
    physAddr == PHYS_WIDTH'(logicalAddr)) else $error("io");
  AST_DMA: assert property (cycleType == l2p_pkg::CYC_DMA |->
    physAddr == dmaAddr) else $error("dma");
  AST_LOW: assert property (m && p < b[3:0] && p < b[7:4] |->
    physAddr == PHYS_WIDTH'(logicalAddr)) else $error("lower");
  AST_SW: assert property (m && p >= b[3:0] && p < b[7:4] |->
    physAddr[PHYS_WIDTH-1:12] == H'(regsOut.switchedBase + p))
    else $error("switched");
  AST_UP: assert property (m && p >= b[7:4] |->
    physAddr[PHYS_WIDTH-1:12] == H'(regsOut.upperBase + p))
    else $error("upper");
  AST_WR: assert property (ioReq.wrEn && ioReq.addr == 8'h39 |=>
    regsOut.switchedBase == $past(ioReq.data)) else $error("write");
  AST_RD: assert property (ioReq.rdEn && ioReq.addr == 8'h3A |=>
    ioRdHit && ioRdData == $past(b)) else $error("read");
  AST_RST: assert property ($rose(rst_n) |->
    regsOut == 24'h0000F0) else $error("reset");
  COV_UP: cover property (m && p >= b[7:4] && b[7:4] != 4'hF);
  COV_DMA: cover property (cycleType == l2p_pkg::CYC_DMA);
  COV_RD: cover property (ioRdHit);
endmodule : l2p_mmu_properties
`default_nettype wire

// >>> verilog/l2p_area_select.sv
// Area comparator: classifies a logical page against the boundary fields
`default_nettype none
module l2p_area_select (
  // Boundary fields
  input  wire logic [3:0]        upperStart,
  input  wire logic [3:0]        switchedStart,
  // Logical page
  input  wire logic [3:0]        page,
  // Result
  output l2p_pkg::l2p_area_t     area
);
  always_comb begin
    if (page >= upperStart) begin // RQ18
      area = l2p_pkg::AREA_UPPER;
    end else if (page >= switchedStart) begin
      area = l2p_pkg::AREA_SWITCHED;
    end else begin
      area = l2p_pkg::AREA_LOWER;
    end
  end
endmodule : l2p_area_select
`default_nettype wire

// >>> verilog/l2p_mmu.sv
// Logical to physical address translation unit with its three registers
//
// Behaviour
// RQ1: Map 16-bit logical to 19/20-bit physical.
// RQ2: Translate combinationally, no added cycle.
// RQ3: Three logical areas, 4k boundaries.
// RQ4: Upper and switched areas relocatable, 4k.
// RQ5: Lower common area based at zero.
// RQ6: Translate every memory cycle kind.
// RQ7: I/O cycles pass address, high bits zero.
// RQ8: DMA cycles drive DMA address directly.
// RQ9: Boundary bits 7-4 give upper start.
// RQ10: Boundary bits 3-0 give switched start.
// RQ11: Software keeps upper start not below switched.
// RQ12: Comparators pick base, added to page.
// RQ13: Each base register serves its area.
// RQ14: Base registers 7 or 8 bits wide.
// RQ15: Reset gives identity map over 64k.
// RQ16: Register writes apply from next cycle.
// RQ17: Software reprograms from an unchanged area.
// RQ18: Upper if page >= start, then switched.
// RQ19: Sum base+page, drop carry, append low.
`include "l2p_mmu_map.svh"
`default_nettype none
module l2p_mmu #(
  parameter int PHYS_WIDTH = 20
) (
  // Clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  // Core address and cycle type
  input  wire logic [15:0]             logicalAddr,
  input  wire l2p_pkg::l2p_cycle_t     cycleType,
  // DMA address
  input  wire logic [PHYS_WIDTH-1:0]   dmaAddr,
  // Internal I/O register port
  input  wire l2p_pkg::l2p_ioreq_t     ioReq,
  output logic [7:0]                   ioRdData,
  output logic                         ioRdHit,
  // Physical address bus
  output logic [PHYS_WIDTH-1:0]        physAddr,
  // Register contents
  output l2p_pkg::l2p_regs_t           regsOut
);
  localparam int BASE_W = PHYS_WIDTH - 12;

  l2p_pkg::l2p_regs_t regs_q;
  l2p_pkg::l2p_regs_t regs_d;
  l2p_pkg::l2p_area_t area;
  logic [BASE_W-1:0]  baseSel;
  logic [BASE_W-1:0]  physPage;
  logic [7:0]         rdData_d;
  logic [7:0]         rdData_q;
  logic               rdHit_d;
  logic               rdHit_q;

  function automatic logic [7:0] l2p_mask_base(input logic [7:0] v);
    logic [7:0] m;
    m = 8'hFF >> (20 - PHYS_WIDTH);
    l2p_mask_base = v & m; // RQ14
  endfunction : l2p_mask_base

  // Register writes over the internal I/O port
  always_comb begin
    regs_d = regs_q;
    if (ioReq.wrEn) begin
      case (ioReq.addr)
        `L2P_UCB_OFFSET: regs_d.upperBase = l2p_mask_base(ioReq.data);
        `L2P_SAB_OFFSET: regs_d.switchedBase = l2p_mask_base(ioReq.data);
        `L2P_ABR_OFFSET: regs_d.areaBoundary = ioReq.data; // RQ9 RQ10
        default: regs_d = regs_q;
      endcase
    end
  end

  // Register reads
  always_comb begin
    rdData_d = 8'h00;
    rdHit_d  = 1'b0;
    if (ioReq.rdEn) begin
      case (ioReq.addr)
        `L2P_UCB_OFFSET: begin
          rdData_d = regs_q.upperBase;
          rdHit_d  = 1'b1;
        end
        `L2P_SAB_OFFSET: begin
          rdData_d = regs_q.switchedBase;
          rdHit_d  = 1'b1;
        end
        `L2P_ABR_OFFSET: begin
          rdData_d = regs_q.areaBoundary;
          rdHit_d  = 1'b1;
        end
        default: begin
          rdData_d = 8'h00;
          rdHit_d  = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      regs_q.areaBoundary <= `L2P_ABR_RESET; // RQ15
      regs_q.upperBase    <= `L2P_BASE_RESET;
      regs_q.switchedBase <= `L2P_BASE_RESET;
      rdData_q            <= 8'h00;
      rdHit_q             <= 1'b0;
    end else begin
      regs_q   <= regs_d; // RQ16
      rdData_q <= rdData_d;
      rdHit_q  <= rdHit_d;
    end
  end

  assign ioRdData = rdData_q;
  assign ioRdHit  = rdHit_q;
  assign regsOut  = regs_q;

  // Area classification
  l2p_area_select u_area (
    .upperStart    (regs_q.areaBoundary[`L2P_ABR_UCS_MSB:`L2P_ABR_UCS_LSB]),
    .switchedStart (regs_q.areaBoundary[`L2P_ABR_SAS_MSB:`L2P_ABR_SAS_LSB]),
    .page          (logicalAddr[15:12]),
    .area          (area)
  ); // RQ3 RQ12

  // Base selection and page arithmetic
  always_comb begin
    case (area)
      l2p_pkg::AREA_UPPER:    baseSel = regs_q.upperBase[BASE_W-1:0]; // RQ13
      l2p_pkg::AREA_SWITCHED: baseSel = regs_q.switchedBase[BASE_W-1:0]; // RQ4
      default:                baseSel = '0; // RQ5
    endcase
    physPage = baseSel + {{(BASE_W-4){1'b0}}, logicalAddr[15:12]}; // RQ19
  end

  // Output mux by cycle type, no pipeline stage
  always_comb begin
    case (cycleType)
      l2p_pkg::CYC_MEM: physAddr = {physPage, logicalAddr[11:0]}; // RQ1 RQ2 RQ6
      l2p_pkg::CYC_IO:  physAddr = {{(PHYS_WIDTH-16){1'b0}}, logicalAddr}; // RQ7
      l2p_pkg::CYC_DMA: physAddr = dmaAddr; // RQ8
      default:          physAddr = {{(PHYS_WIDTH-16){1'b0}}, logicalAddr};
    endcase
  end
endmodule : l2p_mmu
`default_nettype wire

// >>> verilog/l2p_mmu_map.svh
// Register offsets, field positions and reset values of the translation unit
`ifndef L2P_MMU_MAP_SVH
`define L2P_MMU_MAP_SVH
`define L2P_UCB_OFFSET   8'h38
`define L2P_SAB_OFFSET   8'h39
`define L2P_ABR_OFFSET   8'h3A
`define L2P_ABR_UCS_MSB  7
`define L2P_ABR_UCS_LSB  4
`define L2P_ABR_SAS_MSB  3
`define L2P_ABR_SAS_LSB  0
`define L2P_ABR_RESET    8'hF0
`define L2P_BASE_RESET   8'h00
`define L2P_IO_HI_MASK   8'h00
`endif

// >>> verilog/l2p_pkg.sv
// Types shared by the translation unit
`default_nettype none
package l2p_pkg;
  typedef enum logic [1:0] {
    CYC_MEM,
    CYC_IO,
    CYC_DMA,
    CYC_IDLE
  } l2p_cycle_t;

  typedef enum logic [1:0] {
    AREA_LOWER,
    AREA_SWITCHED,
    AREA_UPPER
  } l2p_area_t;

  typedef struct packed {
    logic [7:0] upperBase;
    logic [7:0] switchedBase;
    logic [7:0] areaBoundary;
  } l2p_regs_t;

  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] data;
  } l2p_ioreq_t;
endpackage : l2p_pkg
`default_nettype wire
